//--- verilog/mcu_alu_add_and_flags.sv
// Add and logic datapath with flags and power status, on an Avalon slave.
//
// Behaviour
// - Power-down flag reads 1 after reset and after each watchdog clear.
// - Sleep instruction clears the power-down flag to 0.
// - Timeout flag becomes 1 after reset, watchdog clear and sleep.
// - Watchdog expiry clears the timeout flag to 0.
// - General page operand is six bits, addressing locations 0x00 to 0x3F.
// - Secondary page operand is four bits, addressing 0x0 to 0xF.
// - Register add with carry sums register, work and carry; sets Z,DC,C.
// - Destination 0 writes the work register, 1 writes the operand back.
// - Register add sums work and operand without carry; sets Z,DC,C.
// - Immediate add with carry sums work, immediate, carry into work.
// - Immediate add sums work and immediate into work; sets Z,DC,C.
// - Register AND routes by destination and updates only the zero flag.
// - Carry is 1 on carry out of bit 7 for additions.
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module mcu_alu_add_and_flags (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave.
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Watchdog and power interface.
  input  wire logic        watchdogExpire,
  output logic             powerDownFlag,
  output logic             timeoutFlag,
  output logic             sleepRequest
);

  // Datapath state.
  logic [31:0] instr_reg;
  logic [7:0]  work_reg;
  logic        carry_reg;
  logic        half_reg;
  logic        zero_reg;
  logic        pdown_reg;
  logic        timeout_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        sleep_reg;
  logic [7:0]  gpMem [alu_pkg::GP_DEPTH];
  logic [7:0]  spMem [alu_pkg::SP_DEPTH];

  // Bus decode.
  logic        busRead;
  logic        busWrite;
  logic        hitGp;
  logic        hitSp;
  logic [5:0]  gpIdx;
  logic [3:0]  spIdx;

  // Execute stage.
  logic        execValid;
  logic [31:0] instr_next;
  logic [3:0]  execOp;
  logic        execDest;
  logic [2:0]  execBit;
  logic [5:0]  execReg;
  logic        execPage;
  logic [7:0]  execImm;
  logic [7:0]  operand;
  logic [7:0]  addB;
  logic        addCin;
  logic [7:0]  addSum;
  logic        addCarry;
  logic        addHalf;
  logic [7:0]  result;
  logic        isAdd;
  logic        isRegOp;
  logic        writeResult;
  logic [7:0]  clearMask;

  // Merges enabled byte lanes of new data into an old word.
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0]  lanes
  );
    logic [31:0] merged;
    merged = oldWord;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        merged[8*i +: 8] = newWord[8*i +: 8];
      end
    end
    return merged;
  endfunction

  // Tells whether an address falls in a page window of the given depth.
  function automatic logic inPage(
    input logic [9:0] addr,
    input logic [9:0] base,
    input int         depth
  );
    logic [9:0] top;
    top = base + 10'(4 * depth);
    return (addr >= base) && (addr < top) && (addr[1:0] == 2'b00);
  endfunction

  // Transfers complete in the cycle after the request arrives.
  assign waitrequest = (read || write) && !ack_reg;
  assign busRead     = read && !waitrequest;
  assign busWrite    = write && !waitrequest;
  assign readdata    = rdata_reg;

  // Page windows: one word per location, index from the word address.
  assign hitGp = inPage(address, alu_pkg::ADDR_GP_BASE, alu_pkg::GP_DEPTH);
  assign hitSp = inPage(address, alu_pkg::ADDR_SP_BASE, alu_pkg::SP_DEPTH);
  assign gpIdx = address[7:2];
  assign spIdx = address[5:2];

  // A write to the instruction register launches one operation.
  assign instr_next = mergeBytes(instr_reg, writedata, byteenable);
  assign execValid  = busWrite && (address == alu_pkg::ADDR_INSTR);
  assign execOp     = instr_next[alu_pkg::OP_LSB +: 4];
  assign execDest   = instr_next[alu_pkg::DEST_POS];
  assign execBit    = instr_next[alu_pkg::BIT_LSB +: 3];
  assign execReg    = instr_next[alu_pkg::REG_LSB +: 6];
  assign execPage   = instr_next[alu_pkg::PAGE_POS];
  assign execImm    = instr_next[alu_pkg::IMM_LSB +: 8];

  // Operand fetch from the selected page.
  always_comb begin
    if (execPage) begin
      operand = spMem[execReg[3:0]];
    end else begin
      operand = gpMem[execReg];
    end
  end

  // Second adder input and carry in by operation.
  always_comb begin
    addB   = operand;
    addCin = 1'b0;
    isAdd  = 1'b0;
    case (execOp)
      alu_pkg::OP_ADD_REG: begin
        isAdd = 1'b1;
      end
      alu_pkg::OP_ADD_REG_CARRY: begin
        isAdd  = 1'b1;
        addCin = carry_reg;
      end
      alu_pkg::OP_ADD_IMM: begin
        isAdd = 1'b1;
        addB  = execImm;
      end
      alu_pkg::OP_ADD_IMM_CARRY: begin
        isAdd  = 1'b1;
        addB   = execImm;
        addCin = carry_reg;
      end
      default: begin
        isAdd = 1'b0;
      end
    endcase
  end

  alu_adder8 adder (
    .opA      (work_reg),
    .opB      (addB),
    .carryIn  (addCin),
    .sum      (addSum),
    .carryOut (addCarry),
    .halfOut  (addHalf)
  );

  // Result selection and destination routing.
  always_comb begin
    clearMask   = ~(8'h01 << execBit);
    result      = addSum;
    isRegOp     = 1'b0;
    writeResult = 1'b0;
    case (execOp)
      alu_pkg::OP_ADD_REG, alu_pkg::OP_ADD_REG_CARRY: begin
        isRegOp     = 1'b1;
        writeResult = 1'b1;
      end
      alu_pkg::OP_ADD_IMM, alu_pkg::OP_ADD_IMM_CARRY: begin
        writeResult = 1'b1;
      end
      alu_pkg::OP_AND_REG: begin
        result      = work_reg & operand;
        isRegOp     = 1'b1;
        writeResult = 1'b1;
      end
      alu_pkg::OP_BIT_CLEAR: begin
        result      = operand & clearMask;
        isRegOp     = 1'b1;
        writeResult = 1'b1;
      end
      default: begin
        writeResult = 1'b0;
      end
    endcase
  end

  // Instruction register keeps the last launched word for read back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_reg <= alu_pkg::INSTR_RESET;
    end else if (execValid) begin
      instr_reg <= instr_next;
    end
  end

  // Work register: software writes, or results routed to it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      work_reg <= alu_pkg::WORK_RESET;
    end else if (busWrite && address == alu_pkg::ADDR_WORK
                 && byteenable[0]) begin
      work_reg <= writedata[7:0];
    end else if (execValid && writeResult
                 && execOp != alu_pkg::OP_BIT_CLEAR
                 && (!isRegOp || !execDest)) begin
      work_reg <= result;
    end
  end

  // Register pages: software writes, or results written back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < alu_pkg::GP_DEPTH; i++) begin
        gpMem[i] <= alu_pkg::DATA_RESET;
      end
      for (int j = 0; j < alu_pkg::SP_DEPTH; j++) begin
        spMem[j] <= alu_pkg::DATA_RESET;
      end
    end else if (busWrite && hitGp && byteenable[0]) begin
      gpMem[gpIdx] <= writedata[7:0];
    end else if (busWrite && hitSp && byteenable[0]) begin
      spMem[spIdx] <= writedata[7:0];
    end else if (execValid && writeResult && isRegOp
                 && (execDest || execOp == alu_pkg::OP_BIT_CLEAR)) begin
      if (execPage) begin
        spMem[execReg[3:0]] <= result;
      end else begin
        gpMem[execReg] <= result;
      end
    end
  end

  // Arithmetic flags: additions set all three, AND sets only zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_reg <= alu_pkg::CARRY_RESET;
      half_reg  <= alu_pkg::HALF_RESET;
      zero_reg  <= alu_pkg::ZERO_RESET;
    end else if (busWrite && address == alu_pkg::ADDR_STATUS
                 && byteenable[0]) begin
      carry_reg <= writedata[alu_pkg::ST_CARRY];
      half_reg  <= writedata[alu_pkg::ST_HALF];
      zero_reg  <= writedata[alu_pkg::ST_ZERO];
    end else if (execValid && isAdd) begin
      carry_reg <= addCarry;
      half_reg  <= addHalf;
      zero_reg  <= (addSum == 8'h00);
    end else if (execValid && execOp == alu_pkg::OP_AND_REG) begin
      zero_reg  <= (result == 8'h00);
    end
  end

  // Power-down flag: set by watchdog clear, cleared by sleep.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdown_reg <= alu_pkg::PDOWN_RESET;
    end else if (execValid && execOp == alu_pkg::OP_WATCHDOG_CLEAR) begin
      pdown_reg <= 1'b1;
    end else if (execValid && execOp == alu_pkg::OP_SLEEP) begin
      pdown_reg <= 1'b0;
    end
  end

  // Timeout flag: expiry wins so that a timeout is never lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout_reg <= alu_pkg::TIMEOUT_RESET;
    end else if (watchdogExpire) begin
      timeout_reg <= 1'b0;
    end else if (execValid && (execOp == alu_pkg::OP_WATCHDOG_CLEAR
                               || execOp == alu_pkg::OP_SLEEP)) begin
      timeout_reg <= 1'b1;
    end
  end

  // One-cycle halt request after a sleep instruction.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_reg <= 1'b0;
    end else begin
      sleep_reg <= execValid && execOp == alu_pkg::OP_SLEEP;
    end
  end

  assign powerDownFlag = pdown_reg;
  assign timeoutFlag   = timeout_reg;
  assign sleepRequest  = sleep_reg;

  // Bus acknowledge and registered read data, ready one cycle on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= alu_pkg::UNMAPPED_DATA;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
      if (read && !ack_reg) begin
        if (address == alu_pkg::ADDR_INSTR) begin
          rdata_reg <= instr_reg;
        end else if (address == alu_pkg::ADDR_WORK) begin
          rdata_reg <= {24'h00_0000, work_reg};
        end else if (address == alu_pkg::ADDR_STATUS) begin
          rdata_reg <= {27'h000_0000, timeout_reg, pdown_reg,
                        zero_reg, half_reg, carry_reg};
        end else if (hitGp) begin
          rdata_reg <= {24'h00_0000, gpMem[gpIdx]};
        end else if (hitSp) begin
          rdata_reg <= {24'h00_0000, spMem[spIdx]};
        end else begin
          rdata_reg <= alu_pkg::UNMAPPED_DATA;
        end
      end
    end
  end

  // Reference sums used only by the checks below.
  logic [8:0] refImmSum;
  logic [8:0] refRegSum;
  assign refImmSum = {1'b0, work_reg} + {1'b0, execImm};
  assign refRegSum = {1'b0, work_reg} + {1'b0, operand} + {8'h00, carry_reg};

  // Launch of a given operation in this cycle.
  sequence sExec(logic [3:0] o);
    execValid && execOp == o;
  endsequence

  // Launch of an operation with destination 0 in this cycle.
  sequence sExecToWork(logic [3:0] o);
    execValid && execOp == o && !execDest;
  endsequence

  chk_pd_clear_sets: assert property (
    @(posedge clk) disable iff (rst)
    sExec(alu_pkg::OP_WATCHDOG_CLEAR) |=> powerDownFlag ##1 1'b1
  ) else $error("power-down flag not set by watchdog clear");

  chk_pd_sleep_clears: assert property (
    @(posedge clk) disable iff (rst)
    sExec(alu_pkg::OP_SLEEP) |=> !powerDownFlag && sleepRequest
  ) else $error("sleep did not clear power-down flag");

  chk_to_instr_sets: assert property (
    @(posedge clk) disable iff (rst)
    (sExec(alu_pkg::OP_SLEEP) or sExec(alu_pkg::OP_WATCHDOG_CLEAR))
      ##0 !watchdogExpire |=> timeoutFlag
  ) else $error("timeout flag not set by sleep or watchdog clear");

  chk_to_expiry_clears: assert property (
    @(posedge clk) disable iff (rst)
    watchdogExpire |=> !timeoutFlag
  ) else $error("watchdog expiry did not clear timeout flag");

  chk_adc_reg_sum: assert property (
    @(posedge clk) disable iff (rst)
    sExecToWork(alu_pkg::OP_ADD_REG_CARRY) |=>
      work_reg == $past(refRegSum[7:0]) && carry_reg == $past(refRegSum[8])
  ) else $error("register add with carry gave a wrong sum or carry");

  chk_dest_reg_keeps: assert property (
    @(posedge clk) disable iff (rst)
    sExec(alu_pkg::OP_ADD_REG) ##0 execDest |=> $stable(work_reg)
  ) else $error("destination 1 disturbed the work register");

  chk_add_imm_carry: assert property (
    @(posedge clk) disable iff (rst)
    sExec(alu_pkg::OP_ADD_IMM) |=>
      work_reg == $past(refImmSum[7:0]) && carry_reg == $past(refImmSum[8])
  ) else $error("immediate add gave a wrong sum or carry");

  chk_and_flags_kept: assert property (
    @(posedge clk) disable iff (rst)
    sExec(alu_pkg::OP_AND_REG) |=>
      $stable(carry_reg) && $stable(half_reg)
      && zero_reg == ($past(result) == 8'h00)
  ) else $error("register AND changed carry or half carry");

  chk_bitclr_flags: assert property (
    @(posedge clk) disable iff (rst)
    sExec(alu_pkg::OP_BIT_CLEAR) |=>
      $stable(carry_reg) && $stable(half_reg) && $stable(zero_reg)
  ) else $error("bit clear changed a status flag");

  chk_zero_follows: assert property (
    @(posedge clk) disable iff (rst)
    execValid && isAdd |=> zero_reg == ($past(addSum) == 8'h00)
      && half_reg == $past(addHalf)
  ) else $error("zero or half carry flag wrong after addition");

endmodule

//--- verilog/alu_pkg.sv
// Constants, encodings and register map shared by the datapath files.
package alu_pkg;

  // Operation codes carried in the low nibble of an instruction word.
  typedef enum logic [3:0] {
    OP_NOP            = 4'h0,
    OP_ADD_REG        = 4'h1,
    OP_ADD_REG_CARRY  = 4'h2,
    OP_ADD_IMM        = 4'h3,
    OP_ADD_IMM_CARRY  = 4'h4,
    OP_AND_REG        = 4'h5,
    OP_BIT_CLEAR      = 4'h6,
    OP_SLEEP          = 4'h7,
    OP_WATCHDOG_CLEAR = 4'h8
  } op_t;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [9:0] ADDR_INSTR   = 10'h000;
  localparam logic [9:0] ADDR_WORK    = 10'h004;
  localparam logic [9:0] ADDR_STATUS  = 10'h008;
  localparam logic [9:0] ADDR_GP_BASE = 10'h100;
  localparam logic [9:0] ADDR_SP_BASE = 10'h200;

  // Register page sizes.
  localparam int GP_DEPTH = 64;
  localparam int SP_DEPTH = 16;

  // Field positions inside an instruction word.
  localparam int OP_LSB   = 0;
  localparam int DEST_POS = 4;
  localparam int BIT_LSB  = 5;
  localparam int REG_LSB  = 8;
  localparam int PAGE_POS = 14;
  localparam int IMM_LSB  = 16;

  // Field positions inside the status register.
  localparam int ST_CARRY   = 0;
  localparam int ST_HALF    = 1;
  localparam int ST_ZERO    = 2;
  localparam int ST_PDOWN   = 3;
  localparam int ST_TIMEOUT = 4;

  // Values after reset.
  localparam logic [7:0]  WORK_RESET    = 8'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [31:0] INSTR_RESET   = 32'h0000_0000;
  localparam logic        CARRY_RESET   = 1'b0;
  localparam logic        HALF_RESET    = 1'b0;
  localparam logic        ZERO_RESET    = 1'b0;
  localparam logic        PDOWN_RESET   = 1'b1;
  localparam logic        TIMEOUT_RESET = 1'b1;

  // Answer to a read of an unmapped address.
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

//--- verilog/alu_adder8.sv
// Eight-bit adder with carry in, carry out of bit 7 and carry out of bit 3.
`timescale 1ns/1ns
module alu_adder8 (
  // Operands.
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic       carryIn,
  // Results.
  output logic      [7:0] sum,
  output logic            carryOut,
  output logic            halfOut
);

  logic [4:0] lowSum;
  logic [4:0] highSum;

  // Two nibble additions expose the carry out of bit 3 directly.
  always_comb begin
    lowSum   = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    highSum  = {1'b0, opA[7:4]} + {1'b0, opB[7:4]} + {4'h0, lowSum[4]};
    sum      = {highSum[3:0], lowSum[3:0]};
    carryOut = highSum[4];
    halfOut  = lowSum[4];
  end

endmodule

//--- testbench/mcu_alu_add_and_flags_tb_top.sv
// Self-checking bench for the add and flags datapath.
`timescale 1ns/1ns
module mcu_alu_add_and_flags_tb_top;
  // Operations that write back into the register operand or into work.
  localparam logic [15:0] REG_OPS = 16'h0026;
  localparam logic [15:0] ALU_OPS = 16'h003e;
  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic [9:0]  address        = 10'h000;
  logic        read           = 1'b0;
  logic        write          = 1'b0;
  logic [31:0] writedata      = 32'h0000_0000;
  logic [3:0]  byteenable     = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        watchdogExpire = 1'b0;
  logic        powerDownFlag;
  logic        timeoutFlag;
  logic        sleepRequest;
  int          miscompares    = 0;
  int          checked        = 0;
  logic [31:0] seed           = 32'h0000_370d;
  logic [7:0]  work           = 8'h00;
  logic        carry          = 1'b0;
  logic        half           = 1'b0;
  logic        zero           = 1'b0;
  logic        pdown          = 1'b1;
  logic        tmo            = 1'b1;
  logic [7:0]  gp [64];
  logic [7:0]  sp [16];

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  mcu_alu_add_and_flags dut (
    .clk            (clk),
    .rst            (rst),
    .address        (address),
    .read           (read),
    .write          (write),
    .writedata      (writedata),
    .byteenable     (byteenable),
    .readdata       (readdata),
    .waitrequest    (waitrequest),
    .watchdogExpire (watchdogExpire),
    .powerDownFlag  (powerDownFlag),
    .timeoutFlag    (timeoutFlag),
    .sleepRequest   (sleepRequest)
  );

  // Xorshift source of repeatable random values.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reference sum that also updates the model flags.
  function automatic logic [7:0] add_ref(logic [7:0] a, logic [7:0] b,
                                         logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    carry = s[8];
    half = h[4];
    zero = s[7:0] == 8'h00;
    return s[7:0];
  endfunction

  // Bus address and model content of a page location.
  function automatic logic [9:0] loc_of(logic pg, logic [5:0] r);
    if (pg) begin
      return alu_pkg::ADDR_SP_BASE + {4'h0, r[3:0], 2'b00};
    end
    return alu_pkg::ADDR_GP_BASE + {2'b00, r, 2'b00};
  endfunction

  function automatic logic [7:0] mem_of(logic pg, logic [5:0] r);
    return pg ? sp[r[3:0]] : gp[r];
  endfunction

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare tasks for bus words and for single flags.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Waits, bounded, for the rising edge at which waitrequest is low.
  task automatic wait_ack();
    int n;
    n = 0;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        miscompares++;
        end_sim();
      end
    end
  endtask

  // Avalon write and read; release follows the completion edge.
  task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    wait_ack();
    write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    wait_ack();
    d = readdata;
    read <= 1'b0;
  endtask

  // Runs one instruction, steps the model and checks every result.
  task automatic exec(input logic [3:0] op, input logic d,
                      input logic [2:0] b, input logic [5:0] r,
                      input logic pg, input logic [7:0] imm);
    logic [7:0]  opd;
    logic [7:0]  res;
    logic [31:0] v;
    opd = mem_of(pg, r);
    res = work;
    case (op)
      alu_pkg::OP_ADD_REG:        res = add_ref(work, opd, 1'b0);
      alu_pkg::OP_ADD_REG_CARRY:  res = add_ref(work, opd, carry);
      alu_pkg::OP_ADD_IMM:        res = add_ref(work, imm, 1'b0);
      alu_pkg::OP_ADD_IMM_CARRY:  res = add_ref(work, imm, carry);
      alu_pkg::OP_AND_REG: begin
        res = work & opd;
        zero = res == 8'h00;
      end
      alu_pkg::OP_BIT_CLEAR: begin
        res = opd;
        res[b] = 1'b0;
      end
      alu_pkg::OP_SLEEP: begin
        pdown = 1'b0;
        tmo = 1'b1;
      end
      alu_pkg::OP_WATCHDOG_CLEAR: begin
        pdown = 1'b1;
        tmo = 1'b1;
      end
      default: res = work;
    endcase
    bus_wr(alu_pkg::ADDR_INSTR, {8'h00, imm, 1'b0, pg, r, b, d, op});
    if ((d & REG_OPS[op]) | (op == alu_pkg::OP_BIT_CLEAR)) begin
      if (pg) sp[r[3:0]] = res;
      else gp[r] = res;
    end else if (ALU_OPS[op]) begin
      work = res;
    end
    @(negedge clk);
    chk_bit("sleep pulse", op == alu_pkg::OP_SLEEP, sleepRequest);
    chk_bit("power down", pdown, powerDownFlag);
    chk_bit("timeout", tmo, timeoutFlag);
    @(negedge clk);
    chk_bit("sleep end", 1'b0, sleepRequest);
    bus_rd(alu_pkg::ADDR_WORK, v);
    chk("work", {24'h00_0000, work}, v);
    bus_rd(alu_pkg::ADDR_STATUS, v);
    chk("status", {27'h000_0000, tmo, pdown, zero, half, carry}, v);
    bus_rd(loc_of(pg, r), v);
    chk("operand", {24'h00_0000, mem_of(pg, r)}, v);
  endtask

  // One-cycle watchdog expiry pulse.
  task automatic expire();
    @(posedge clk);
    watchdogExpire <= 1'b1;
    @(posedge clk);
    watchdogExpire <= 1'b0;
    tmo = 1'b0;
    @(negedge clk);
    chk_bit("timeout", 1'b0, timeoutFlag);
    chk_bit("power down", pdown, powerDownFlag);
  endtask

  // Bound on the whole run.
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  // Main sequence.
  initial begin
    logic [31:0] v;
    int          i;
    for (i = 0; i < 64; i++) gp[i] = 8'h00;
    for (i = 0; i < 16; i++) sp[i] = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_bit("power down", 1'b1, powerDownFlag);
    chk_bit("timeout", 1'b1, timeoutFlag);
    bus_rd(alu_pkg::ADDR_STATUS, v);
    chk("status", 32'h0000_0018, v);
    bus_rd(alu_pkg::ADDR_WORK, v);
    chk("work", 32'h0000_0000, v);
    $display("reset test done");
    for (i = 0; i < 80; i++) begin
      v = rnd();
      if (i < 64) gp[i] = v[7:0];
      else sp[i - 64] = v[7:0];
      bus_wr(loc_of(i >= 64, 6'(i)), {24'h00_0000, v[7:0]});
    end
    for (i = 0; i < 80; i++) begin
      bus_rd(loc_of(i >= 64, 6'(i)), v);
      chk("page", {24'h00_0000, mem_of(i >= 64, 6'(i))}, v);
    end
    bus_wr(10'h240, 32'h0000_00aa);
    bus_rd(10'h240, v);
    chk("unmapped", 32'h0000_0000, v);
    bus_rd(10'h101, v);
    chk("misaligned", 32'h0000_0000, v);
    bus_rd(loc_of(1'b1, 6'h00), v);
    chk("page", {24'h00_0000, sp[0]}, v);
    $display("page test done");
    bus_wr(alu_pkg::ADDR_WORK, 32'h0000_00ff);
    work = 8'hff;
    exec(alu_pkg::OP_ADD_IMM, 1'b1, 3'h0, 6'h00, 1'b0, 8'h01);
    exec(alu_pkg::OP_ADD_IMM_CARRY, 1'b0, 3'h0, 6'h00, 1'b0, 8'h0f);
    bus_wr(alu_pkg::ADDR_WORK, 32'h0000_0012);
    work = 8'h12;
    bus_wr(alu_pkg::ADDR_STATUS, 32'h0000_0001);
    carry = 1'b1;
    half = 1'b0;
    zero = 1'b0;
    gp[5] = 8'h34;
    bus_wr(loc_of(1'b0, 6'h05), 32'h0000_0034);
    exec(alu_pkg::OP_ADD_REG_CARRY, 1'b1, 3'h0, 6'h05, 1'b0, 8'h00);
    exec(alu_pkg::OP_ADD_REG, 1'b0, 3'h0, 6'h05, 1'b0, 8'h00);
    exec(alu_pkg::OP_AND_REG, 1'b1, 3'h0, 6'h3f, 1'b0, 8'h00);
    for (i = 0; i < 8; i++) begin
      exec(alu_pkg::OP_BIT_CLEAR, i[0], 3'(i), 6'h3f, 1'b1, 8'h00);
    end
    exec(4'hf, 1'b1, 3'h0, 6'h05, 1'b0, 8'h00);
    $display("corner test done");
    for (i = 0; i < 60; i++) begin
      v = rnd();
      if (v[31]) bus_wr(alu_pkg::ADDR_WORK, {24'h00_0000, v[30:23]});
      if (v[31]) work = v[30:23];
      exec(4'(v[7:0] % 8'h06) + 4'h1, v[8], v[11:9], v[17:12], v[18],
           v[26:19]);
    end
    $display("random test done");
    exec(alu_pkg::OP_SLEEP, 1'b0, 3'h0, 6'h00, 1'b0, 8'h00);
    expire();
    exec(alu_pkg::OP_WATCHDOG_CLEAR, 1'b0, 3'h0, 6'h00, 1'b0, 8'h00);
    expire();
    exec(alu_pkg::OP_SLEEP, 1'b0, 3'h0, 6'h00, 1'b0, 8'h00);
    exec(alu_pkg::OP_WATCHDOG_CLEAR, 1'b0, 3'h0, 6'h00, 1'b0, 8'h00);
    $display("power flag test done");
    end_sim();
  end
endmodule
